/* File: hdl/jta_link_ctrl.sv */
// transmit link control: alignment sequencer, sample packing, sysref detector
`timescale 1ns/100ps
module jta_link_ctrl #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire logic [11:0]            reg_addr_in,
    input  wire logic [7:0]             reg_wdata_in,
    output logic [7:0]                  reg_rdata_out,
    input  wire jta_pkg::jta_sample_s   sample_in,
    input  wire logic                   sample_valid_in,
    output logic                        sample_ready_out,
    input  wire logic                   sysref_in,
    input  wire logic [7:0]             setup_hit_in,
    input  wire logic [7:0]             hold_hit_in,
    input  wire logic                   six_lane_in,
    input  wire logic                   link_sync_req_in,
    output jta_pkg::jta_word_s          word_out,
    output logic                        word_valid_out,
    input  wire logic                   word_ready_in,
    output logic [7:0]                  lane_power_out,
    output logic                        irq_out,
    output logic                        align_active_out
);
    import jta_pkg::*;

    jta_state_s     s_q;
    jta_state_s     s_d;
    jta_word_s      push_word;
    logic           push_valid;
    logic           fifo_ready;
    logic           sysref_edge;
    logic [1:0]     align_mode;
    logic [2:0]     setup_sel;
    logic [2:0]     hold_sel;
    logic [1:0]     cs_sel;
    logic [16:0]    frame_total;
    logic           frame_last;
    logic           clr_hold;
    logic [11:0]    samp;

    // ************************************************************
    // field decode
    // ************************************************************
    assign align_mode  = s_q.lane_ctrl[ALIGN_MODE_LSB +: 2];
    assign setup_sel   = s_q.setup_gb[GB_LSB +: 3];
    assign hold_sel    = s_q.hold_gb[GB_LSB +: 3];
    assign cs_sel      = s_q.ctrl_bits[CS_LSB +: 2];
    assign clr_hold    = s_q.ts_ctrl[FLAG_CLR_BIT];
    assign sysref_edge = sysref_in && !s_q.sysref_prev;

    // alignment frame total: 4 * (K+1) * (repeat+1)
    assign frame_total = 17'(FRAMES_PER_K * 17'({12'h000, s_q.fpmf[4:0]} + 17'h0_0001)
                         * 17'({9'h000, s_q.repeat_cnt} + 17'h0_0001));
    assign frame_last  = (s_q.frame_cnt == 17'(frame_total - 17'h0_0001));

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d        = s_q;
        push_word  = '0;
        push_valid = 1'b0;
        samp       = sample_in.data;

        s_d.sysref_prev = sysref_in;

        // register writes
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ADDR_TS_CTRL:   s_d.ts_ctrl    = reg_wdata_in;
                ADDR_LANE_CTRL: s_d.lane_ctrl  = reg_wdata_in;
                ADDR_REPEAT:    s_d.repeat_cnt = reg_wdata_in;
                ADDR_FPMF:      s_d.fpmf       = reg_wdata_in;
                ADDR_CTRL_BITS: s_d.ctrl_bits  = reg_wdata_in;
                ADDR_IRQ_MASK:  s_d.mask       = reg_wdata_in;
                ADDR_HOLD_GB:   s_d.hold_gb    = reg_wdata_in;
                ADDR_SETUP_GB:  s_d.setup_gb   = reg_wdata_in;
                default:        s_d.rdata      = s_q.rdata;
            endcase
        end

        // register reads, unmapped offsets read zero
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_TS_CTRL:   s_d.rdata = s_q.ts_ctrl;
                ADDR_LANE_CTRL: s_d.rdata = s_q.lane_ctrl;
                ADDR_REPEAT:    s_d.rdata = s_q.repeat_cnt;
                ADDR_FPMF:      s_d.rdata = s_q.fpmf;
                ADDR_CTRL_BITS: s_d.rdata = s_q.ctrl_bits;
                ADDR_IRQ_STAT: begin
                    s_d.rdata            = 8'h00;
                    s_d.rdata[SETUP_BIT] = s_q.setup_flag;
                    s_d.rdata[HOLD_BIT]  = s_q.hold_flag;
                end
                ADDR_IRQ_MASK:  s_d.rdata = s_q.mask;
                ADDR_HOLD_GB:   s_d.rdata = s_q.hold_gb;
                ADDR_SETUP_GB:  s_d.rdata = s_q.setup_gb;
                default:        s_d.rdata = 8'h00;
            endcase
        end

        // sticky sysref window flags; clear bit holds them at zero
        if (clr_hold) begin
            s_d.setup_flag = 1'b0;
            s_d.hold_flag  = 1'b0;
        end else if (sysref_edge) begin
            // hit vector bit n: edge inside window widened by setting n
            if (setup_hit_in[setup_sel]) begin
                s_d.setup_flag = 1'b1;
            end
            if (hold_hit_in[hold_sel]) begin
                s_d.hold_flag = 1'b1;
            end
        end

        // interrupt pin from enabled flags
        s_d.irq = (s_d.setup_flag && s_d.mask[SETUP_BIT])
               || (s_d.hold_flag && s_d.mask[HOLD_BIT]);

        // unused lanes off in six-lane mode
        s_d.lanes = six_lane_in ? LANES_SIX : LANES_ALL;

        // link sequencer
        unique case (s_q.st)
            JTA_ST_IDLE: begin
                s_d.frame_cnt = '0;
                if (align_mode == ALIGN_ON || align_mode == ALIGN_CONT) begin
                    s_d.st = JTA_ST_ALIGN;
                end else begin
                    s_d.st = JTA_ST_DATA;
                end
            end
            JTA_ST_ALIGN: begin
                push_word.ilas = 1'b1;
                push_word.data = s_q.frame_cnt[15:0];
                push_valid     = 1'b1;
                if (fifo_ready) begin
                    s_d.frame_cnt = 17'(s_q.frame_cnt + 17'h0_0001);
                    if (frame_last) begin
                        s_d.frame_cnt = '0;
                        if (align_mode != ALIGN_CONT) begin
                            s_d.st = JTA_ST_DATA;
                        end
                    end
                end
            end
            JTA_ST_DATA: begin
                // sample packing
                if (six_lane_in) begin
                    if (s_q.ts_ctrl[TS_LSB_BIT]) begin
                        samp[0] = sysref_edge;
                    end
                    push_word.data = {4'h0, samp};
                end else begin
                    if (s_q.ts_ctrl[TS_LSB_BIT]) begin
                        samp[0] = sysref_edge;
                    end
                    push_word.data = {samp, 4'h0};
                    if (cs_sel == CS_OVR || cs_sel == CS_OVR_TS) begin
                        push_word.data[CTL_OVR_BIT] = sample_in.ovr;
                    end
                    if (cs_sel == CS_OVR_TS) begin
                        push_word.data[CTL_TS_BIT] = sysref_edge;
                    end
                end
                push_valid = sample_valid_in;
            end
            default: s_d.st = JTA_ST_IDLE;
        endcase

        // receiver resync returns the sequencer to idle when lane sync is enabled
        if (link_sync_req_in && s_q.lane_ctrl[SYNC_EN_BIT]) begin
            s_d.st        = JTA_ST_IDLE;
            s_d.frame_cnt = '0;
        end

        // alignment indicator for the output pin
        s_d.align_act = (s_d.st == JTA_ST_ALIGN);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q            <= '0;
            s_q.ts_ctrl    <= RST_TS_CTRL;
            s_q.lane_ctrl  <= RST_LANE_CTRL;
            s_q.repeat_cnt <= RST_REPEAT;
            s_q.fpmf       <= RST_FPMF;
            s_q.ctrl_bits  <= RST_CTRL_BITS;
            s_q.mask       <= RST_MASK;
            s_q.hold_gb    <= RST_GB;
            s_q.setup_gb   <= RST_GB;
            s_q.lanes      <= LANES_ALL;
            s_q.st         <= JTA_ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // output word buffer
    // ************************************************************
    jta_fifo #(
        .WIDTH  ($bits(jta_word_s)),
        .DEPTH  (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in     (sys_clk_in),
        .rst_n_in       (rst_n_in),
        .in_data_in     (push_word),
        .in_valid_in    (push_valid),
        .in_ready_out   (fifo_ready),
        .out_data_out   (word_out),
        .out_valid_out  (word_valid_out),
        .out_ready_in   (word_ready_in)
    );

    // port outputs from flip-flops; sample ready is fifo ready gated by the data state
    assign reg_rdata_out    = s_q.rdata;
    assign irq_out          = s_q.irq;
    assign lane_power_out   = s_q.lanes;
    assign align_active_out = s_q.align_act;
    assign sample_ready_out = fifo_ready && (s_q.st == JTA_ST_DATA);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence seq_clr_held;
        s_q.ts_ctrl[FLAG_CLR_BIT] ##1 s_q.ts_ctrl[FLAG_CLR_BIT];
    endsequence

    sequence seq_setup_hit;
        !clr_hold && sysref_edge && setup_hit_in[setup_sel];
    endsequence

    a_flag_clear_hold: assert property (
        seq_clr_held |-> !s_q.setup_flag && !s_q.hold_flag)
        else $error("flags not held clear");

    a_setup_flag_set: assert property (
        seq_setup_hit |=> s_q.setup_flag)
        else $error("setup flag missed edge in window");

    a_hold_flag_set: assert property (
        !clr_hold && sysref_edge && hold_hit_in[hold_sel] |=> s_q.hold_flag)
        else $error("hold flag missed edge in window");

    a_flag_sticky: assert property (
        s_q.setup_flag && !clr_hold |=> s_q.setup_flag [*1])
        else $error("setup flag dropped without clear");

    a_flag_no_cause: assert property (
        !s_q.hold_flag && !(sysref_edge && hold_hit_in[hold_sel]) |=> !s_q.hold_flag)
        else $error("hold flag set without cause");

    a_irq_follow: assert property (
        ((s_q.setup_flag && s_q.mask[SETUP_BIT]) || (s_q.hold_flag && s_q.mask[HOLD_BIT]))
        == s_q.irq)
        else $error("interrupt pin disagrees with enabled flags");

    a_ts_mark: assert property (
        push_valid && fifo_ready && s_q.st == JTA_ST_DATA && !six_lane_in
        && cs_sel == CS_OVR_TS |-> push_word.data[CTL_TS_BIT] == sysref_edge)
        else $error("timestamp mark not on edge sample");

    a_six_no_ctl: assert property (
        push_valid && s_q.st == JTA_ST_DATA && six_lane_in |-> push_word.data[15:12] == 4'h0)
        else $error("six-lane word carries extra bits");

    a_six_lanes_off: assert property (
        six_lane_in |=> lane_power_out == LANES_SIX)
        else $error("unused lanes not powered down");

    a_align_end: assert property (
        s_q.st == JTA_ST_ALIGN && fifo_ready && frame_last && align_mode == ALIGN_ON
        && !link_sync_req_in |=> s_q.st == JTA_ST_DATA && s_q.frame_cnt == 17'h0_0000)
        else $error("alignment did not end after full frame total");

    a_align_off: assert property (
        s_q.st == JTA_ST_IDLE && align_mode == ALIGN_OFF && !link_sync_req_in
        |=> s_q.st == JTA_ST_DATA)
        else $error("alignment ran while disabled");

    a_sync_restart: assert property (
        link_sync_req_in && s_q.lane_ctrl[SYNC_EN_BIT] |=> s_q.st == JTA_ST_IDLE)
        else $error("resync request ignored while enabled");

    a_lsb_stamp: assert property (
        s_q.st == JTA_ST_DATA && push_valid && s_q.ts_ctrl[TS_LSB_BIT] && six_lane_in
        |-> push_word.data[0] == sysref_edge)
        else $error("lsb not replaced by sysref edge");

    a_hold_sticky: assert property (
        s_q.hold_flag && !clr_hold |=> s_q.hold_flag)
        else $error("hold flag dropped without clear");

    a_setup_no_cause: assert property (
        !s_q.setup_flag && !(sysref_edge && setup_hit_in[setup_sel]) |=> !s_q.setup_flag)
        else $error("setup flag set without cause");

    a_irq_held_low: assert property (
        seq_clr_held |-> !irq_out)
        else $error("interrupt pin high while flags held clear");

    a_lanes_all_on: assert property (
        !six_lane_in |=> lane_power_out == LANES_ALL)
        else $error("lane powered down outside six-lane mode");

    a_pack_upper: assert property (
        push_valid && s_q.st == JTA_ST_DATA && !six_lane_in
        |-> push_word.data[15:5] == sample_in.data[11:1] && push_word.data[1:0] == 2'h0)
        else $error("sample not in upper slot bits");

    a_ctl_none: assert property (
        push_valid && s_q.st == JTA_ST_DATA && !six_lane_in && cs_sel == CS_NONE
        |-> push_word.data[CTL_OVR_BIT:0] == 4'h0)
        else $error("control bits sent while off");

    a_ctl_ovr_only: assert property (
        push_valid && s_q.st == JTA_ST_DATA && !six_lane_in && cs_sel == CS_OVR
        |-> push_word.data[CTL_OVR_BIT:CTL_TS_BIT] == {sample_in.ovr, 1'b0})
        else $error("overrange bit wrong");

    a_align_cont: assert property (
        s_q.st == JTA_ST_ALIGN && align_mode == ALIGN_CONT && !link_sync_req_in
        |=> s_q.st == JTA_ST_ALIGN)
        else $error("continuous alignment stopped");

    a_align_start: assert property (
        s_q.st == JTA_ST_IDLE && align_mode == ALIGN_ON && !link_sync_req_in
        |=> s_q.st == JTA_ST_ALIGN && s_q.frame_cnt == 17'h0_0000)
        else $error("alignment did not start");

    a_sync_ignored: assert property (
        link_sync_req_in && !s_q.lane_ctrl[SYNC_EN_BIT] && s_q.st == JTA_ST_DATA
        |=> s_q.st == JTA_ST_DATA)
        else $error("resync taken while lane sync off");

endmodule

/* File: hdl/jta_pkg.sv */
// constants, field layouts and carrier types of the transmit link control block
// ****************************************************************************
// Operation
// - two-bit alignment mode: 00 off, 01 on, 10 reserved, 11 continuous test
// - repeat count n runs the alignment sequence n+1 times
// - alignment frames total four times (K+1) times (repeat count+1)
// - lane synchronisation enable bit: 1 on, 0 off
// - LSB timestamp enable puts captured rising sysref into every sample LSB
// - control-bit timestamping only outside six-lane mode; six-lane allows LSB only
// - six-lane mode packs 12-bit samples unpadded, two lanes powered down
// - 16-bit slots with 12-bit data leave four spare bits, two usable
// - control field: 00 none, 01 overrange, 10 overrange plus sysref mark
// - sysref mark set only on the sample coincident with a rising edge
// - setup or hold flag set when sysref edge lands in its window
// - flags readable in interrupt status and routed to interrupt pin by mask
// - two three-bit guardband fields widen setup and hold windows; 000 none
// - seven further guardband settings widen the window progressively
// - setup flag bit 2, hold flag bit 3; masks at same positions
// - flags stay set until explicitly cleared
// - clear bit at 1 forces and holds both flags at 0 until written 0
// ****************************************************************************
package jta_pkg;

    // register offsets
    localparam int              ADDR_W          = 12;
    localparam logic [11:0]     ADDR_TS_CTRL    = 12'h03a;
    localparam logic [11:0]     ADDR_LANE_CTRL  = 12'h05f;
    localparam logic [11:0]     ADDR_REPEAT     = 12'h062;
    localparam logic [11:0]     ADDR_FPMF       = 12'h070;
    localparam logic [11:0]     ADDR_CTRL_BITS  = 12'h072;
    localparam logic [11:0]     ADDR_IRQ_STAT   = 12'h100;
    localparam logic [11:0]     ADDR_IRQ_MASK   = 12'h101;
    localparam logic [11:0]     ADDR_HOLD_GB    = 12'h13b;
    localparam logic [11:0]     ADDR_SETUP_GB   = 12'h13c;

    // field positions
    localparam int              ALIGN_MODE_LSB  = 2;
    localparam int              SYNC_EN_BIT     = 4;
    localparam int              TS_LSB_BIT      = 7;
    localparam int              FLAG_CLR_BIT    = 6;
    localparam int              CS_LSB          = 6;
    localparam int              GB_LSB          = 5;
    localparam int              SETUP_BIT       = 2;
    localparam int              HOLD_BIT        = 3;
    localparam int              CTL_OVR_BIT     = 3;
    localparam int              CTL_TS_BIT      = 2;

    // field encodings
    localparam logic [1:0]      ALIGN_OFF       = 2'h0;
    localparam logic [1:0]      ALIGN_ON        = 2'h1;
    localparam logic [1:0]      ALIGN_CONT      = 2'h3;
    localparam logic [1:0]      CS_NONE         = 2'h0;
    localparam logic [1:0]      CS_OVR          = 2'h1;
    localparam logic [1:0]      CS_OVR_TS       = 2'h2;
    localparam logic [7:0]      LANES_SIX       = 8'h3f;
    localparam logic [7:0]      LANES_ALL       = 8'hff;
    localparam logic [16:0]     FRAMES_PER_K    = 17'h0_0004;

    // reset values
    localparam logic [7:0]      RST_TS_CTRL     = 8'h00;
    localparam logic [7:0]      RST_LANE_CTRL   = 8'h14;
    localparam logic [7:0]      RST_REPEAT      = 8'h00;
    localparam logic [7:0]      RST_FPMF        = 8'h1f;
    localparam logic [7:0]      RST_CTRL_BITS   = 8'h00;
    localparam logic [7:0]      RST_MASK        = 8'h00;
    localparam logic [7:0]      RST_GB          = 8'h00;

    // link sequencer states
    typedef enum logic [1:0] {
        JTA_ST_IDLE,
        JTA_ST_ALIGN,
        JTA_ST_DATA
    } jta_link_e;

    // one converter sample with its overrange
    typedef struct packed {
        logic           ovr;
        logic [11:0]    data;
    } jta_sample_s;

    // one outgoing link word
    typedef struct packed {
        logic           ilas;
        logic [15:0]    data;
    } jta_word_s;

    // all state of the link control block
    typedef struct packed {
        logic [7:0]     ts_ctrl;
        logic [7:0]     lane_ctrl;
        logic [7:0]     repeat_cnt;
        logic [7:0]     fpmf;
        logic [7:0]     ctrl_bits;
        logic [7:0]     mask;
        logic [7:0]     hold_gb;
        logic [7:0]     setup_gb;
        logic           setup_flag;
        logic           hold_flag;
        logic           irq;
        logic           align_act;
        logic [7:0]     rdata;
        logic [7:0]     lanes;
        logic           sysref_prev;
        jta_link_e      st;
        logic [16:0]    frame_cnt;
    } jta_state_s;

endpackage

/* File: hdl/jta_fifo.sv */
// word fifo with registered output stage and registered ready
`timescale 1ns/100ps
module jta_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input  wire logic               sys_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic [WIDTH-1:0]   in_data_in,
    input  wire logic               in_valid_in,
    output logic                    in_ready_out,
    output logic [WIDTH-1:0]        out_data_out,
    output logic                    out_valid_out,
    input  wire logic               out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0]  wptr;
        logic [AW-1:0]  rptr;
        logic [AW:0]    count;
        logic           ready;
        logic           ovalid;
        logic [WIDTH-1:0] odata;
    } jta_fifo_s;

    jta_fifo_s          s_q;
    jta_fifo_s          s_d;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic               push;
    logic               pop;

    // push, pop into output stage, pointer and count update
    always_comb begin
        s_d  = s_q;
        push = in_valid_in && s_q.ready;
        pop  = (s_q.count != '0) && (!s_q.ovalid || out_ready_in);
        if (out_ready_in && s_q.ovalid) begin
            s_d.ovalid = 1'b0;
        end
        if (pop) begin
            s_d.odata  = mem[s_q.rptr];
            s_d.ovalid = 1'b1;
            s_d.rptr   = AW'(s_q.rptr + 1'b1);
        end
        if (push) begin
            s_d.wptr = AW'(s_q.wptr + 1'b1);
        end
        s_d.count = (AW+1)'(s_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        s_d.ready = (s_d.count != (AW+1)'(DEPTH));
    end

    // state register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q       <= '0;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // storage array
    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[s_q.wptr] <= in_data_in;
        end
    end

    assign in_ready_out  = s_q.ready;
    assign out_data_out  = s_q.odata;
    assign out_valid_out = s_q.ovalid;
endmodule

/* File: sim/jta_rx_model.sv */
// receiving link partner: takes words, can stall, tallies alignment and data words
`timescale 1ns/100ps
module jta_rx_model (
    input  wire logic               sys_clk_in,
    input  wire logic               rst_n_in,
    input  wire jta_pkg::jta_word_s word_in,
    input  wire logic               valid_in,
    input  wire logic               slow_in,
    output logic                    ready_out,
    output int                      ilas_cnt_out,
    output int                      data_cnt_out,
    output logic [15:0]             last_out
);
    import jta_pkg::*;
    logic ph_q;
    // slow mode only accepts every other cycle
    assign ready_out = slow_in ? ph_q : 1'b1;
    // accept on valid and ready, sort alignment frames from data
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ph_q         <= 1'b0;
            ilas_cnt_out <= 0;
            data_cnt_out <= 0;
            last_out     <= 16'h0000;
        end else begin
            ph_q <= ~ph_q;
            if (valid_in && ready_out) begin
                if (word_in.ilas) begin
                    ilas_cnt_out <= ilas_cnt_out + 1;
                end else begin
                    data_cnt_out <= data_cnt_out + 1;
                    last_out     <= word_in.data;
                end
            end
        end
    end
endmodule

/* File: sim/test_jta_link_ctrl.sv */
// register-driven testbench of the transmit link control block
`timescale 1ns/100ps
`define JTA_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_jta_link_ctrl;
    import jta_pkg::*;
    logic clk, rst_n, wr, rd, sv, srdy, sr, six, sreq, wv, wrdy, irq, act, slow;
    logic [11:0] addr;
    logic [7:0]  wd, rdat, sh, hh, lp;
    logic [15:0] last;
    jta_sample_s smp;
    jta_word_s   wo;
    int          err_total, num_checks, ilas, dcnt, n0;
    logic [11:0] ra[8] = '{ADDR_TS_CTRL, ADDR_LANE_CTRL, ADDR_REPEAT, ADDR_FPMF,
                           ADDR_CTRL_BITS, ADDR_IRQ_MASK, ADDR_HOLD_GB, ADDR_SETUP_GB};
    logic [7:0]  rv[8] = '{8'h00, 8'h14, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [4:0]  sc[8] = '{5'b00001, 5'b01001, 5'b10001, 5'b10000, 5'b10101, 5'b00111,
                           5'b10011, 5'b11001};
    logic [7:0]  lc[4] = '{8'h14, 8'h10, 8'h18, 8'h04};
    int          ef[4] = '{4 * (4 + 1) * (2 + 1), 0, 0, 0};
    jta_link_ctrl dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdat), .sample_in(smp),
        .sample_valid_in(sv), .sample_ready_out(srdy), .sysref_in(sr), .setup_hit_in(sh),
        .hold_hit_in(hh), .six_lane_in(six), .link_sync_req_in(sreq), .word_out(wo),
        .word_valid_out(wv), .word_ready_in(wrdy), .lane_power_out(lp), .irq_out(irq),
        .align_active_out(act));
    jta_rx_model rx_u (.sys_clk_in(clk), .rst_n_in(rst_n), .word_in(wo), .valid_in(wv),
        .slow_in(slow), .ready_out(wrdy), .ilas_cnt_out(ilas), .data_cnt_out(dcnt),
        .last_out(last));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk); wr = 1'b1; addr = a; wd = d;
        @(negedge clk); wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk); rd = 1'b1; addr = a;
        @(negedge clk); rd = 1'b0;
        `JTA_CHK("rdata", e, rdat)
    endtask
    task automatic bail(input int n);
        if (n > 3000) begin err_total++; end_sim(); end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (act !== 1'b0) begin @(negedge clk); n++; bail(n); end
        repeat (60) @(negedge clk);
    endtask
    task automatic pulse(input logic [7:0] s, input logic [7:0] h);
        @(negedge clk); sh = s; hh = h; sr = 1'b1;
        @(negedge clk); sr = 1'b0; sh = 8'h00; hh = 8'h00;
        @(negedge clk);
    endtask
    task automatic send(input logic [11:0] d, input logic stamp);
        int n;
        n = 0;
        @(negedge clk); smp = '{ovr: 1'b1, data: d}; sv = 1'b1;
        while (srdy !== 1'b1) begin @(negedge clk); n++; bail(n); end
        sr = stamp;
        n0 = dcnt;
        @(negedge clk); sv = 1'b0; sr = 1'b0;
        while (dcnt == n0) begin @(negedge clk); n++; bail(n); end
    endtask
    function automatic logic [15:0] pack(input logic [4:0] c, input logic [11:0] d);
        logic [11:0] s;
        s = c[1] ? {d[11:1], c[0]} : d;
        if (c[2]) return {4'h0, s};
        return {s, c[4:3] == 2'b01 || c[4:3] == 2'b10, c[0] && c[4:3] == 2'b10, 2'b00};
    endfunction
    // main sequence
    initial begin
        {rst_n, wr, rd, sv, sr, six, sreq} = '0;
        {addr, wd, sh, hh} = '0;
        smp = '0;
        slow = 1'b1;
        err_total = 0;
        num_checks = 0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) rd_chk(ra[i], rv[i]);
        rd_chk(12'h000, 8'h00);
        wait_idle();
        `JTA_CHK("reset frames", 4 * (31 + 1) * (0 + 1), ilas)
        $display("test reset done");
        wr_reg(ADDR_SETUP_GB, 8'h60);
        wr_reg(ADDR_HOLD_GB, 8'ha0);
        wr_reg(ADDR_IRQ_MASK, 8'h04);
        pulse(8'hf7, 8'hdf);
        rd_chk(ADDR_IRQ_STAT, 8'h00);
        pulse(8'h08, 8'h10);
        rd_chk(ADDR_IRQ_STAT, 8'h04);
        `JTA_CHK("irq", 1'b1, irq)
        pulse(8'h00, 8'h20);
        rd_chk(ADDR_IRQ_STAT, 8'h0c);
        pulse(8'h00, 8'h00);
        rd_chk(ADDR_IRQ_STAT, 8'h0c);
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        `JTA_CHK("irq", 1'b0, irq)
        wr_reg(ADDR_IRQ_MASK, 8'h08);
        `JTA_CHK("irq", 1'b1, irq)
        wr_reg(ADDR_IRQ_STAT, 8'hff);
        rd_chk(ADDR_IRQ_STAT, 8'h0c);
        wr_reg(ADDR_TS_CTRL, 8'h40);
        rd_chk(ADDR_IRQ_STAT, 8'h00);
        pulse(8'h08, 8'h20);
        rd_chk(ADDR_IRQ_STAT, 8'h00);
        `JTA_CHK("irq", 1'b0, irq)
        wr_reg(ADDR_TS_CTRL, 8'h00);
        pulse(8'h08, 8'h00);
        rd_chk(ADDR_IRQ_STAT, 8'h04);
        $display("test flags done");
        slow = 1'b0;
        for (int i = 0; i < 8; i++) begin
            wr_reg(ADDR_CTRL_BITS, {sc[i][4:3], 6'h00});
            wr_reg(ADDR_TS_CTRL, {sc[i][1], 7'h00});
            six = sc[i][2];
            repeat (2) @(negedge clk);
            `JTA_CHK("lanes", sc[i][2] ? LANES_SIX : LANES_ALL, lp)
            send(12'ha5c, sc[i][0]);
            `JTA_CHK("word", pack(sc[i], 12'ha5c), last)
        end
        $display("test packing done");
        slow = 1'b1;
        wr_reg(ADDR_FPMF, 8'h04);
        wr_reg(ADDR_REPEAT, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_LANE_CTRL, lc[i]);
            n0 = ilas;
            @(negedge clk); sreq = 1'b1;
            @(negedge clk); sreq = 1'b0;
            repeat (3) @(negedge clk);
            wait_idle();
            `JTA_CHK("frames", ef[i], ilas - n0)
        end
        wr_reg(ADDR_LANE_CTRL, 8'h1c);
        @(negedge clk); sreq = 1'b1;
        @(negedge clk); sreq = 1'b0;
        repeat (300) @(negedge clk);
        `JTA_CHK("continuous", 1'b1, act)
        $display("test alignment done");
        end_sim();
    end
endmodule
